// ---- rtl/fpbp_programmer.sv ----
// programmer controller that walks a fuse prom word by word, bit by bit
`timescale 1ns/1ps
`default_nettype none
`include "fpbp_consts.svh"
module fpbp_programmer #(
  parameter int ADDR_W = 11,
  parameter int DATA_W = 8,
  parameter int WORDS = 2048
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic nrst,
  // user side
  input wire logic start,
  input wire logic [DATA_W-1:0] want_data,
  output logic busy,
  output logic done,
  output logic [ADDR_W-1:0] want_addr,
  output logic fail,
  // device pins
  output logic [ADDR_W-1:0] prom_addr,
  output fpbp_pkg::fpbp_drive_t drive,
  input wire logic [DATA_W-1:0] prom_data,
  output logic [DATA_W-1:0] out_clamp_en,
  output logic [DATA_W-1:0] out_pulse_en
);
  import fpbp_pkg::*;

  localparam int C_SETTLE = `FPBP_CYC_DN(`FPBP_T_SETTLE_NS);
  localparam int C_SUP_SEL = `FPBP_CYC(`FPBP_T_SUP_SEL_NS);
  localparam int C_SEL_RAMP = `FPBP_CYC(`FPBP_T_SEL_RAMP_NS);
  localparam int C_RAMP = `FPBP_CYC(`FPBP_T_RAMP_NS);
  localparam int C_FLAT = `FPBP_CYC_DN(`FPBP_T_FLAT_NS);
  localparam int C_DESEL = `FPBP_CYC(`FPBP_T_DESEL_NS);
  localparam int C_SEL_OFF = `FPBP_CYC(`FPBP_T_SEL_OFF_NS);
  localparam int C_COOL = `FPBP_CYC(`FPBP_T_COOL_NS);
  localparam int C_WCOOL = `FPBP_CYC(`FPBP_T_WCOOL_NS);
  localparam int CNT_W = 13;
  localparam int BIT_W = $clog2(DATA_W);

  logic rst_s1_ff;
  logic rst_n_ff;
  fpbp_state_t state_ff;
  fpbp_state_t nxt_state;
  logic [CNT_W-1:0] cnt_ff;
  logic [BIT_W-1:0] bit_ff;
  logic [ADDR_W-1:0] addr_ff;
  logic vhigh_ff;
  logic fail_ff;
  logic seq_end;
  logic word_end;
  logic bit_wanted;

  // reset release through two flops so nothing leaves reset mid-edge
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      rst_s1_ff <= 1'b0;
      rst_n_ff <= 1'b0;
    end else begin
      rst_s1_ff <= 1'b1;
      rst_n_ff <= rst_s1_ff;
    end
  end

  // cycle count at which the current state ends
  function automatic logic [CNT_W-1:0] state_len(input fpbp_state_t s);
    case (s)
      FPBP_CHECK: state_len = CNT_W'(C_SETTLE);
      FPBP_SUPPLY: state_len = CNT_W'(C_SUP_SEL);
      FPBP_SELECT: state_len = CNT_W'(C_SEL_RAMP);
      FPBP_RAMP: state_len = CNT_W'(C_RAMP);
      FPBP_FLAT: state_len = CNT_W'(C_FLAT);
      FPBP_DESEL: state_len = CNT_W'(C_DESEL);
      FPBP_SUPOFF: state_len = CNT_W'(C_SEL_OFF);
      FPBP_COOL: state_len = CNT_W'(C_COOL);
      FPBP_WCOOL: state_len = CNT_W'(C_WCOOL);
      FPBP_VERIFY: state_len = CNT_W'(C_SETTLE);
      default: state_len = CNT_W'(1);
    endcase
  endfunction

  assign seq_end = (cnt_ff == state_len(state_ff) - CNT_W'(1));
  assign word_end = (bit_ff == BIT_W'(DATA_W - 1));
  assign bit_wanted = want_data[bit_ff];

  // sequencer: each timed state runs its full count then steps on
  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      FPBP_IDLE: if (start) nxt_state = FPBP_ADDR;
      FPBP_ADDR: nxt_state = FPBP_CHECK;
      FPBP_CHECK: begin
        // a wanted-low bit needs nothing; a bit already high is done
        if (seq_end) begin
          if (!bit_wanted || prom_data[bit_ff]) begin
            nxt_state = word_end ? FPBP_WCOOL : FPBP_CHECK;
          end else begin
            nxt_state = FPBP_SUPPLY;
          end
        end
      end
      FPBP_SUPPLY: if (seq_end) nxt_state = FPBP_SELECT;
      FPBP_SELECT: if (seq_end) nxt_state = FPBP_RAMP;
      FPBP_RAMP: if (seq_end) nxt_state = FPBP_FLAT;
      FPBP_FLAT: if (seq_end) nxt_state = FPBP_DESEL;
      FPBP_DESEL: if (seq_end) nxt_state = FPBP_SUPOFF;
      FPBP_SUPOFF: if (seq_end) nxt_state = FPBP_COOL;
      FPBP_COOL: begin
        if (seq_end) begin
          nxt_state = word_end ? FPBP_WCOOL : FPBP_ADDR;
        end
      end
      FPBP_WCOOL: begin
        if (seq_end) begin
          if (addr_ff == ADDR_W'(WORDS - 1)) nxt_state = FPBP_VERIFY;
          else nxt_state = FPBP_ADDR;
        end
      end
      FPBP_VERIFY: begin
        if (seq_end && addr_ff == ADDR_W'(WORDS - 1) && vhigh_ff) begin
          nxt_state = FPBP_DONE;
        end
      end
      FPBP_DONE: nxt_state = FPBP_IDLE;
      default: nxt_state = FPBP_IDLE;
    endcase
  end

  always_ff @(posedge ref_clk or negedge rst_n_ff) begin
    if (!rst_n_ff) state_ff <= FPBP_IDLE;
    else state_ff <= nxt_state;
  end

  // interval counter restarts on every state change or bit step
  always_ff @(posedge ref_clk or negedge rst_n_ff) begin
    if (!rst_n_ff) cnt_ff <= '0;
    else if (nxt_state != state_ff || seq_end) cnt_ff <= '0;
    else cnt_ff <= cnt_ff + CNT_W'(1);
  end

  // bit and word walk
  always_ff @(posedge ref_clk or negedge rst_n_ff) begin
    if (!rst_n_ff) begin
      bit_ff <= '0;
      addr_ff <= '0;
      vhigh_ff <= 1'b0;
    end else begin
      if (state_ff == FPBP_IDLE && start) begin
        bit_ff <= '0;
        addr_ff <= '0;
        vhigh_ff <= 1'b0;
      end else if (seq_end && (state_ff == FPBP_CHECK || state_ff == FPBP_COOL)) begin
        if (!word_end) bit_ff <= bit_ff + BIT_W'(1);
      end else if (seq_end && state_ff == FPBP_WCOOL) begin
        bit_ff <= '0;
        if (addr_ff != ADDR_W'(WORDS - 1)) addr_ff <= addr_ff + ADDR_W'(1);
        else addr_ff <= '0;
      end else if (seq_end && state_ff == FPBP_VERIFY) begin
        // first pass at low supply, second at high supply
        if (addr_ff == ADDR_W'(WORDS - 1)) begin
          addr_ff <= '0;
          vhigh_ff <= 1'b1;
        end else begin
          addr_ff <= addr_ff + ADDR_W'(1);
        end
      end
    end
  end

  // a mismatch in either verify pass is sticky until the next start
  always_ff @(posedge ref_clk or negedge rst_n_ff) begin
    if (!rst_n_ff) fail_ff <= 1'b0;
    else if (state_ff == FPBP_IDLE && start) fail_ff <= 1'b0;
    else if (state_ff == FPBP_VERIFY && seq_end && prom_data != want_data) fail_ff <= 1'b1;
  end

  // pin drive, registered so levels change cleanly on state edges
  always_ff @(posedge ref_clk or negedge rst_n_ff) begin
    if (!rst_n_ff) begin
      drive <= '0;
      out_clamp_en <= '0;
      out_pulse_en <= '0;
      prom_addr <= '0;
    end else begin
      prom_addr <= addr_ff;
      drive <= '0;
      out_clamp_en <= '0;
      out_pulse_en <= '0;
      case (nxt_state)
        FPBP_ADDR, FPBP_CHECK, FPBP_WCOOL: begin
          drive.supply_level <= `FPBP_SUP_NORM;
          drive.select_active <= 1'b1;
        end
        FPBP_SUPPLY: drive.supply_level <= `FPBP_SUP_PROG;
        FPBP_SELECT, FPBP_RAMP, FPBP_FLAT: begin
          drive.supply_level <= `FPBP_SUP_PROG;
          drive.select_program_level <= 1'b1;
          // one target bit, every other output held low
          out_clamp_en <= ~(DATA_W'(1) << bit_ff);
          if (nxt_state != FPBP_SELECT) out_pulse_en <= DATA_W'(1) << bit_ff;
          drive.pulse_ramp <= (nxt_state == FPBP_RAMP);
          drive.output_pulse_level <= (nxt_state == FPBP_FLAT);
        end
        FPBP_DESEL: begin
          // clamps dropped, selects still at program level
          drive.supply_level <= `FPBP_SUP_PROG;
          drive.select_program_level <= 1'b1;
        end
        FPBP_SUPOFF: drive.supply_level <= `FPBP_SUP_PROG;
        FPBP_VERIFY: begin
          drive.supply_level <= vhigh_ff ? `FPBP_SUP_VHIGH : `FPBP_SUP_VLOW;
          drive.select_active <= 1'b1;
        end
        default: drive.supply_level <= `FPBP_SUP_OFF;
      endcase
    end
  end

  assign busy = (state_ff != FPBP_IDLE);
  assign done = (state_ff == FPBP_DONE);
  assign want_addr = addr_ff;
  assign fail = fail_ff;

  // assertion helpers: how long the ramp, the flat top and the supply-off gap have stood, in clock cycles
  logic [CNT_W-1:0] ramp_cyc_ff;
  logic [CNT_W-1:0] flat_cyc_ff;
  logic [CNT_W-1:0] off_cyc_ff;

  // ramp length seen on the pins, not the state count, so a bad decode shows up
  always_ff @(posedge ref_clk or negedge rst_n_ff) begin
    if (!rst_n_ff) ramp_cyc_ff <= '0;
    else if (drive.pulse_ramp) ramp_cyc_ff <= ramp_cyc_ff + CNT_W'(1);
    else ramp_cyc_ff <= '0;
  end

  // flat top length of the output pulse
  always_ff @(posedge ref_clk or negedge rst_n_ff) begin
    if (!rst_n_ff) flat_cyc_ff <= '0;
    else if (drive.output_pulse_level) flat_cyc_ff <= flat_cyc_ff + CNT_W'(1);
    else flat_cyc_ff <= '0;
  end

  // supply-off time; wraps harmlessly while idle since only the cool exit is checked
  always_ff @(posedge ref_clk or negedge rst_n_ff) begin
    if (!rst_n_ff) off_cyc_ff <= '0;
    else if (drive.supply_level == `FPBP_SUP_OFF) off_cyc_ff <= off_cyc_ff + CNT_W'(1);
    else off_cyc_ff <= '0;
  end

  // the flat top stays up for at least 8 cycles after it rises
  a_flat_length: assert property (@(posedge ref_clk) disable iff (!rst_n_ff)
    $rose(drive.output_pulse_level) |=> drive.output_pulse_level [*8])
    else $error("output pulse flat top cut short");

  a_pulse_clamp: assert property (@(posedge ref_clk) disable iff (!rst_n_ff)
    drive.output_pulse_level |-> (out_clamp_en & out_pulse_en) == '0 && $onehot(out_pulse_en))
    else $error("pulse target also clamped or not one-hot");

  a_no_prog_unchk: assert property (@(posedge ref_clk) disable iff (!rst_n_ff)
    $rose(drive.select_program_level) |-> drive.supply_level == `FPBP_SUP_PROG)
    else $error("select raised without program supply");

  a_release_order: assert property (@(posedge ref_clk) disable iff (!rst_n_ff)
    $fell(drive.output_pulse_level) |-> out_clamp_en == '0 && drive.select_program_level)
    else $error("clamps not released while selects still high");

  a_desel_then_off: assert property (@(posedge ref_clk) disable iff (!rst_n_ff)
    $fell(drive.select_program_level) |-> drive.supply_level == `FPBP_SUP_PROG
      ##[1:20] drive.supply_level == `FPBP_SUP_OFF)
    else $error("supply not brought down after deselect");

  a_check_normal: assert property (@(posedge ref_clk) disable iff (!rst_n_ff)
    state_ff == FPBP_CHECK |-> drive.supply_level == `FPBP_SUP_NORM
      && drive.select_active && out_pulse_en == '0)
    else $error("check without normal supply and active selects");

  a_skip_set_bit: assert property (@(posedge ref_clk) disable iff (!rst_n_ff)
    state_ff == FPBP_CHECK && seq_end && prom_data[bit_ff] |=> state_ff != FPBP_SUPPLY)
    else $error("already set bit entered programming");

  a_ramp_before: assert property (@(posedge ref_clk) disable iff (!rst_n_ff)
    $rose(drive.pulse_ramp) |-> $past(drive.select_program_level))
    else $error("ramp started before selects at program level");

  a_verify_level: assert property (@(posedge ref_clk) disable iff (!rst_n_ff)
    state_ff == FPBP_VERIFY |-> drive.supply_level == `FPBP_SUP_VLOW
      || drive.supply_level == `FPBP_SUP_VHIGH)
    else $error("verify at a supply other than low or high");

  a_ramp_count: assert property (@(posedge ref_clk) disable iff (!rst_n_ff)
    $fell(drive.pulse_ramp) |-> ramp_cyc_ff == CNT_W'(C_RAMP))
    else $error("ramp length wrong");

  a_flat_count: assert property (@(posedge ref_clk) disable iff (!rst_n_ff)
    $fell(drive.output_pulse_level) |-> flat_cyc_ff == CNT_W'(C_FLAT))
    else $error("flat top length wrong");

  // the supply-off gap after a programmed bit is the cooling time
  a_bit_cool: assert property (@(posedge ref_clk) disable iff (!rst_n_ff)
    drive.supply_level == `FPBP_SUP_NORM && $past(state_ff) == FPBP_COOL
      |-> off_cyc_ff == CNT_W'(C_COOL))
    else $error("bit cooling gap wrong");

  a_ramp_then_flat: assert property (@(posedge ref_clk) disable iff (!rst_n_ff)
    $fell(drive.pulse_ramp) |-> drive.output_pulse_level)
    else $error("ramp not followed by flat top");

  a_one_hot_pulse: assert property (@(posedge ref_clk) disable iff (!rst_n_ff)
    out_pulse_en != '0 |-> $onehot(out_pulse_en) && out_clamp_en == ~out_pulse_en)
    else $error("pulse drive on more than one output");

  a_prog_after_chk: assert property (@(posedge ref_clk) disable iff (!rst_n_ff)
    $rose(drive.supply_level == `FPBP_SUP_PROG) |-> $past(state_ff) == FPBP_CHECK)
    else $error("program supply without a preceding check");

  a_skip_no_supply: assert property (@(posedge ref_clk) disable iff (!rst_n_ff)
    state_ff == FPBP_CHECK && seq_end && !bit_wanted
      |=> drive.supply_level != `FPBP_SUP_PROG)
    else $error("unwanted bit got program supply");

  a_addr_steady: assert property (@(posedge ref_clk) disable iff (!rst_n_ff)
    state_ff == FPBP_CHECK |-> prom_addr == addr_ff)
    else $error("address pins not on the word under check");

  a_fail_sticky: assert property (@(posedge ref_clk) disable iff (!rst_n_ff)
    fail_ff && !(state_ff == FPBP_IDLE && start) |=> fail_ff)
    else $error("verify failure flag dropped");

  a_desel_no_pulse: assert property (@(posedge ref_clk) disable iff (!rst_n_ff)
    $fell(drive.select_program_level) |-> out_pulse_en == '0 && !drive.pulse_ramp)
    else $error("selects dropped while pulse still applied");
endmodule
`default_nettype wire

// ---- rtl/fpbp_consts.svh ----
// timing and level constants for the fuse prom bit programmer
`ifndef FPBP_CONSTS_SVH
`define FPBP_CONSTS_SVH
`define FPBP_CLK_MHZ 125
// times in nanoseconds
`define FPBP_T_SETTLE_NS 10000
`define FPBP_T_SUP_SEL_NS 5000
`define FPBP_T_SEL_RAMP_NS 100
`define FPBP_T_RAMP_NS 10000
`define FPBP_T_FLAT_NS 20000
`define FPBP_T_DESEL_NS 5000
`define FPBP_T_SEL_OFF_NS 100
`define FPBP_T_COOL_NS 30000
`define FPBP_T_WCOOL_NS 30000
// cycle counts, least times rounded up, longest times rounded down
`define FPBP_CYC(ns) (((ns) * `FPBP_CLK_MHZ + 999) / 1000)
`define FPBP_CYC_DN(ns) (((ns) * `FPBP_CLK_MHZ) / 1000)
// supply level codes
`define FPBP_SUP_OFF 3'h0
`define FPBP_SUP_NORM 3'h1
`define FPBP_SUP_PROG 3'h2
`define FPBP_SUP_VLOW 3'h3
`define FPBP_SUP_VHIGH 3'h4
`endif

// ---- rtl/fpbp_pkg.sv ----
// types for the fuse prom bit programmer
package fpbp_pkg;
  typedef enum logic [3:0] {
    FPBP_IDLE = 4'h0,
    FPBP_ADDR = 4'h1,
    FPBP_CHECK = 4'h3,
    FPBP_SUPPLY = 4'h2,
    FPBP_SELECT = 4'h6,
    FPBP_RAMP = 4'h7,
    FPBP_FLAT = 4'h5,
    FPBP_DESEL = 4'h4,
    FPBP_SUPOFF = 4'hC,
    FPBP_COOL = 4'hD,
    FPBP_WCOOL = 4'hF,
    FPBP_VERIFY = 4'hE,
    FPBP_DONE = 4'hA
  } fpbp_state_t;
  // analog drive request to the pin electronics
  typedef struct packed {
    logic [2:0] supply_level;
    logic select_active;
    logic select_program_level;
    logic pulse_ramp;
    logic output_pulse_level;
  } fpbp_drive_t;
endpackage

// ---- verif/fpbp_prom_model.sv ----
// behavioural fuse prom answering the programmer's pins
`timescale 1ns/1ps
`default_nettype none
`include "fpbp_consts.svh"
module fpbp_prom_model #(
  parameter int WORDS = 2
) (
  // clock used only to sample the pins
  input wire logic ref_clk,
  // pins from the programmer
  input wire logic [10:0] prom_addr,
  input wire fpbp_pkg::fpbp_drive_t drive,
  input wire logic [7:0] out_clamp_en,
  input wire logic [7:0] out_pulse_en,
  // device outputs
  output logic [7:0] prom_data
);
  import fpbp_pkg::*;
  logic [7:0] mem [WORDS];
  logic [7:0] last_ff;
  logic rd_en;
  logic blow_en;
  int idx;
  assign idx = int'(prom_addr) % WORDS;
  // reads only at a read supply with selects active; otherwise the pins float and wander
  assign rd_en = drive.select_active && !drive.select_program_level &&
    (drive.supply_level inside {`FPBP_SUP_NORM, `FPBP_SUP_VLOW, `FPBP_SUP_VHIGH});
  assign prom_data = rd_en ? mem[idx] : ~last_ff;
  // a fuse opens only under full program conditions, one output at a time
  assign blow_en = drive.output_pulse_level && drive.select_program_level &&
    drive.supply_level == `FPBP_SUP_PROG && $onehot(out_pulse_en) &&
    out_clamp_en == ~out_pulse_en;
  // blank part reads all low
  initial begin
    last_ff = 8'h00;
    foreach (mem[i]) mem[i] = 8'h00;
  end
  // bits only ever go from low to high, never back
  always @(posedge ref_clk) begin
    last_ff <= prom_data;
    if (blow_en) mem[idx] <= mem[idx] | out_pulse_en;
  end
endmodule
`default_nettype wire

// ---- verif/testbench.sv ----
// self-checking bench for the fuse prom bit programmer
`timescale 1ns/1ps
`default_nettype none
`include "fpbp_consts.svh"
`define CHK(a, b) begin comparisons++; if ((a) !== (b)) begin errors++; $display("unexpected at %0t: got %h expected %h", $time, (a), (b)); end end
module testbench;
  import fpbp_pkg::*;
  localparam int WORDS = 2;
  logic ref_clk, nrst, start, busy, done, fail;
  logic [7:0] want_data, prom_data, out_clamp_en, out_pulse_en;
  logic [10:0] want_addr, prom_addr, pd_addr;
  fpbp_drive_t drive, pd;
  logic [7:0] want_tab [WORDS];
  logic [7:0] pre [WORDS];
  int errors = 0, comparisons = 0, cycles = 0, pulses = 0, exp_pulses = 0;
  int c_sup = 0, c_sel = 0, c_ramp = 0, c_flat = 0, c_end = 100000, c_nrm = 0;
  bit seen_lo, seen_hi;
  // wanted word follows the requested index straight away
  assign want_data = want_tab[want_addr[0]];
  fpbp_programmer #(.WORDS(WORDS)) u_fpbp_programmer (
    .ref_clk(ref_clk), .nrst(nrst), .start(start), .want_data(want_data),
    .busy(busy), .done(done), .want_addr(want_addr), .fail(fail),
    .prom_addr(prom_addr), .drive(drive), .prom_data(prom_data),
    .out_clamp_en(out_clamp_en), .out_pulse_en(out_pulse_en));
  fpbp_prom_model #(.WORDS(WORDS)) u_fpbp_prom_model (
    .ref_clk(ref_clk), .prom_addr(prom_addr), .drive(drive),
    .out_clamp_en(out_clamp_en), .out_pulse_en(out_pulse_en), .prom_data(prom_data));
  function automatic int need(input logic [7:0] w, input logic [7:0] p);
    return $countones(w & ~p);
  endfunction
  task automatic complete_run();
    $display("errors %0d comparisons %0d", errors, comparisons);
    if (errors == 0 && comparisons > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  // edge-to-edge timing of the program pins, in clock cycles; also the hang guard
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 98000) begin
      errors++;
      complete_run();
    end
    c_sup++; c_sel++; c_ramp++; c_flat++; c_end++; c_nrm++;
    if (drive.supply_level == `FPBP_SUP_VLOW) seen_lo = 1'b1;
    if (drive.supply_level == `FPBP_SUP_VHIGH) seen_hi = 1'b1;
    if (drive.supply_level == `FPBP_SUP_PROG && pd.supply_level != `FPBP_SUP_PROG) c_sup = 0;
    if (drive.supply_level == `FPBP_SUP_NORM && pd.supply_level != `FPBP_SUP_NORM) c_nrm = 0;
    if (drive.supply_level == `FPBP_SUP_PROG && pd.supply_level == `FPBP_SUP_NORM)
      `CHK(c_nrm >= 1250, 1'b1)
    if (prom_addr != pd_addr && busy && !seen_lo)
      `CHK(c_nrm >= 3750, 1'b1)
    if (drive.supply_level != `FPBP_SUP_PROG && pd.supply_level == `FPBP_SUP_PROG)
      `CHK(drive.select_program_level, 1'b0)
    if (drive.select_program_level && !pd.select_program_level) begin
      `CHK(c_sup >= 625 && c_sup <= 1250, 1'b1)
      c_sel = 0;
    end
    if (drive.pulse_ramp && !pd.pulse_ramp) begin
      `CHK(c_sel >= 13 && c_sel <= 1250, 1'b1)
      `CHK(c_end >= 3750, 1'b1)
      c_ramp = 0;
    end
    if (drive.output_pulse_level && !pd.output_pulse_level) begin
      `CHK(c_ramp >= 1250 && c_ramp <= 2500, 1'b1)
      `CHK({drive.supply_level, drive.select_program_level}, {`FPBP_SUP_PROG, 1'b1})
      `CHK({$onehot(out_pulse_en), out_clamp_en}, {1'b1, ~out_pulse_en})
      `CHK(prom_addr, want_addr)
      pulses++;
      c_flat = 0;
    end
    if (!drive.output_pulse_level && pd.output_pulse_level) begin
      `CHK(c_flat >= 1875 && c_flat <= 2500, 1'b1)
      c_end = 0;
    end
    if (!drive.select_program_level && pd.select_program_level) begin
      `CHK(c_end >= 625 && c_end <= 1250, 1'b1)
      `CHK(out_clamp_en, 8'h00)
    end
    pd = drive;
    pd_addr = prom_addr;
  end
  // one whole run, with a second start thrown in while busy that must be ignored
  task automatic run_once(input logic exp_fail);
    int n;
    seen_lo = 1'b0;
    seen_hi = 1'b0;
    start = 1'b1;
    @(posedge ref_clk) #1 start = 1'b0;
    `CHK(busy, 1'b1)
    repeat (200) @(posedge ref_clk);
    #1 start = 1'b1;
    @(posedge ref_clk) #1 start = 1'b0;
    `CHK(busy, 1'b1)
    n = 0;
    while (done !== 1'b1 && n < 70000) begin
      @(posedge ref_clk);
      n++;
    end
    `CHK({done, seen_lo, seen_hi, fail}, {3'b111, exp_fail})
    `CHK(pulses, exp_pulses)
    for (int i = 0; i < WORDS; i++)
      `CHK(u_fpbp_prom_model.mem[i], want_tab[i] | pre[i])
    repeat (2) @(posedge ref_clk);
    #1;
    `CHK({done, busy}, 2'b00)
  endtask
  initial begin
    ref_clk = 1'b0;
    forever #4 ref_clk = ~ref_clk;
  end
  initial begin
    int r;
    void'($urandom(32'hc543));
    nrst = 1'b0;
    start = 1'b0;
    r = $urandom % 8;
    want_tab[0] = 8'h81;
    want_tab[1] = 8'h01 << r;
    repeat (6) @(posedge ref_clk);
    #1 nrst = 1'b1;
    repeat (3) @(posedge ref_clk);
    #1;
    // bit 0 of word 0 is already blown, so only the rest gets pulsed
    pre[0] = 8'h01;
    pre[1] = 8'h00;
    u_fpbp_prom_model.mem[0] = pre[0];
    exp_pulses = need(want_tab[0], pre[0]) + need(want_tab[1], pre[1]);
    run_once(1'b0);
    // second run on a done part with one stray blown bit: no pulses, verify must flag it
    pre[0] = want_tab[0] | pre[0];
    pre[1] = want_tab[1] | (8'h01 << ((r + 1) % 8));
    u_fpbp_prom_model.mem[1] = pre[1];
    run_once(1'b1);
    complete_run();
  end
endmodule
`default_nettype wire
